// [hdl/afe_ctrl_defines.vh]
// Purpose: Register map, field positions and coded values for the front-end control bank
// Assumes: 8-bit registers on a plain strobe port
// Notes:   Definitions only
`ifndef AFE_CTRL_DEFINES_VH
`define AFE_CTRL_DEFINES_VH

`define ADDR_W             8
`define DATA_W             8
`define OFF_INT_STATUS     8'h04
`define OFF_INT_MASK       8'h05
`define OFF_INPUT_CFG      8'h10
`define OFF_SYNC_SEL       8'h11
`define OFF_SYNC_CHOSEN    8'h12
`define RST_INT_STATUS     8'h00
`define RST_INT_MASK       8'hFF
`define RST_INPUT_CFG      8'h00
`define RST_SYNC_SEL       8'h00
`define RST_CHAN_FLAGS     4'h0
`define RST_FLAG           1'b0
`define RST_CHAN           2'h0
`define RST_CFG_BIT        1'b0
`define RST_CLAMP_LEVEL    3'h0
`define RST_BLACK_TARGET   24'h000000
`define RST_SYNC_FF        4'h0
`define RST_RDATA          8'h00
`define NO_BITS            8'h00
`define CHOSEN_PAD         6'h00
`define ST_CHAN_LO         0
`define ST_CHAN_HI         3
`define CFG_CHAN_LO        0
`define CFG_CHAN_HI        1
`define CFG_DIFF           2
`define CFG_DC             3
`define CFG_FORMAT         4
`define CFG_RANGE          5
`define CFG_CLAMP_SRC      6
`define CFG_CLAMP_POL      7
`define SYNC_MANUAL        0
`define SYNC_H_SRC         1
`define SYNC_V_SRC         2
`define ST_DISRUPT         4
`define ST_SETTLED         5
`define ST_VSYNC           6
`define ST_PADJ            7
`define TARGET_ZERO        8'h00
`define TARGET_MID         8'h80
`define CLAMP_300MV        1'b0
`define CLAMP_600MV        1'b1

`endif

// [hdl/afe_ctrl_regs.v]
// Purpose: Interrupt status/mask and input configuration registers of the video front end
// Assumes: Event inputs are single-cycle pulses on clock_i; activity levels are asynchronous
// Notes:   Reads return data one cycle after the read strobe; unmapped reads return zero
`timescale 1ns/10ps
`include "afe_ctrl_defines.vh"

// Operation
// - Channel sync change sets status bits 0-3
// - Writing ones clears matching status bits
// - Selected input sync disruption sets bit 4
// - Selected input sync settled sets bit 5
// - Vertical sync event sets bit 6
// - Phase adjust completion sets bit 7
// - Mask resets all ones; zero enables
// - Unmasked status bits raise interrupt
// - Channel select field steers input muxes
// - Bit 2 selects single-ended or differential
// - Bit 3 selects AC or DC coupling
// - Format sets clamp level and target
// - Bit 5 selects expanded input range
// - Bit 6 selects external clamp source
// - Bit 7 sets external clamp polarity
// - Automatic sync pick reported in status
// - Manual bit 1 picks horizontal source
// - Manual bit 2 picks vertical source
module afe_ctrl_regs (
  input  wire       clock_i,
  input  wire       resetn_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       write_i,
  input  wire       read_i,
  output reg  [7:0] rdata_o,
  input  wire [3:0] channel_sync_change_i,
  input  wire       input_disrupted_i,
  input  wire       input_settled_i,
  input  wire       vsync_event_i,
  input  wire       phase_adjust_done_i,
  input  wire [3:0] hsync_active_i,
  input  wire [3:0] green_embedded_sync_active_i,
  output wire       irq_o,
  output reg  [1:0] channel_select_o,
  output reg        differential_o,
  output reg        dc_coupled_o,
  output reg        colour_format_select_o,
  output reg        expanded_range_o,
  output reg        clamp_source_select_o,
  output reg        clamp_polarity_select_o,
  output reg  [2:0] clamp_level_o,
  output reg  [23:0] black_target_o,
  output reg        hsync_from_green_o,
  output reg        vsync_from_separator_o
);

  // Status flags, one register per event source
  reg  [3:0]  channel_sync_change_flag;
  reg         input_disrupted_flag;
  reg         input_settled_flag;
  reg         vsync_flag;
  reg         phase_adjust_done_flag;

  // Register file
  wire [7:0]  interrupt_status;
  reg  [7:0]  interrupt_mask;
  reg  [7:0]  input_configuration;
  reg  [7:0]  sync_source_selection;

  // Activity level resynchronisers
  reg  [3:0]  hact_meta;
  reg  [3:0]  hact_sync;
  reg  [3:0]  gact_meta;
  reg  [3:0]  gact_sync;

  // Automatic sync pick
  reg         auto_h_green;
  reg         auto_v_sep;
  wire        sel_hact;
  wire        sel_gact;
  wire        next_auto_green;

  // Host write decode and status update
  wire        write_status;
  wire        write_mask;
  wire        write_config;
  wire        write_sync_sel;
  wire [7:0]  events;
  wire [7:0]  clear_bits;
  wire [7:0]  next_status;
  wire [7:0]  pending;

  // Configuration fields and read path
  wire [1:0]  chan;
  wire        component_format;
  wire        manual_sync;
  wire [7:0]  sync_chosen;
  reg  [7:0]  next_rdata;

  // Exact address match shared by the four write decodes; the read mux uses its own case
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Set wins over a clear in the same cycle so no event is lost
  function [7:0] flag_next;
    input [7:0] old;
    input [7:0] clear;
    input [7:0] set;
    begin
      flag_next = (old & ~clear) | set;
    end
  endfunction

  // Clamp level per channel, {red, green, blue}; green stays at the low level
  function [2:0] clamp_for;
    input component;
    begin
      if (component) begin
        clamp_for = {`CLAMP_600MV, `CLAMP_300MV, `CLAMP_600MV};
      end else begin
        clamp_for = {`CLAMP_300MV, `CLAMP_300MV, `CLAMP_300MV};
      end
    end
  endfunction

  // Black target code per channel, {red, green, blue}; green never moves
  function [23:0] target_for;
    input component;
    begin
      if (component) begin
        target_for = {`TARGET_MID, `TARGET_ZERO, `TARGET_MID};
      end else begin
        target_for = {`TARGET_ZERO, `TARGET_ZERO, `TARGET_ZERO};
      end
    end
  endfunction

  // Manual mode takes the host's bit, automatic mode the detector's pick
  function pick_source;
    input manual;
    input manual_bit;
    input auto_bit;
    begin
      pick_source = manual ? manual_bit : auto_bit;
    end
  endfunction

  assign write_status   = write_i & hit(addr_i, `OFF_INT_STATUS);
  assign write_mask     = write_i & hit(addr_i, `OFF_INT_MASK);
  assign write_config   = write_i & hit(addr_i, `OFF_INPUT_CFG);
  assign write_sync_sel = write_i & hit(addr_i, `OFF_SYNC_SEL);

  assign events = {phase_adjust_done_i,
                   vsync_event_i,
                   input_settled_i,
                   input_disrupted_i,
                   channel_sync_change_i};
  assign interrupt_status = {phase_adjust_done_flag,
                             vsync_flag,
                             input_settled_flag,
                             input_disrupted_flag,
                             channel_sync_change_flag};
  assign clear_bits  = write_status ? wdata_i : `NO_BITS;
  assign next_status = flag_next(interrupt_status, clear_bits, events);
  // Masked bits still latch; the mask gates only the request line
  assign pending     = interrupt_status & ~interrupt_mask;
  assign irq_o       = |pending;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_sync_change_flag <= `RST_CHAN_FLAGS;
    end else begin
      channel_sync_change_flag <= next_status[`ST_CHAN_HI:`ST_CHAN_LO];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_disrupted_flag <= `RST_FLAG;
    end else begin
      input_disrupted_flag <= next_status[`ST_DISRUPT];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_settled_flag <= `RST_FLAG;
    end else begin
      input_settled_flag <= next_status[`ST_SETTLED];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vsync_flag <= `RST_FLAG;
    end else begin
      vsync_flag <= next_status[`ST_VSYNC];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_adjust_done_flag <= `RST_FLAG;
    end else begin
      phase_adjust_done_flag <= next_status[`ST_PADJ];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interrupt_mask <= `RST_INT_MASK;
    end else if (write_mask) begin
      interrupt_mask <= wdata_i;
    end
  end

  // Channels 2 and 3 in differential mode are accepted as written; host must avoid them
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_configuration <= `RST_INPUT_CFG;
    end else if (write_config) begin
      input_configuration <= wdata_i;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_source_selection <= `RST_SYNC_SEL;
    end else if (write_sync_sel) begin
      sync_source_selection <= wdata_i;
    end
  end

  // Activity levels come from the analog detectors, so resynchronise first
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hact_meta <= `RST_SYNC_FF;
      hact_sync <= `RST_SYNC_FF;
    end else begin
      hact_meta <= hsync_active_i;
      hact_sync <= hact_meta;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gact_meta <= `RST_SYNC_FF;
      gact_sync <= `RST_SYNC_FF;
    end else begin
      gact_meta <= green_embedded_sync_active_i;
      gact_sync <= gact_meta;
    end
  end

  assign chan             = input_configuration[`CFG_CHAN_HI:`CFG_CHAN_LO];
  assign component_format = input_configuration[`CFG_FORMAT];
  assign manual_sync      = sync_source_selection[`SYNC_MANUAL];
  assign sel_hact         = hact_sync[chan];
  assign sel_gact         = gact_sync[chan];
  // Prefer the dedicated pin; green-embedded sync only when the pin is idle,
  // and then vertical sync must come from the separator
  assign next_auto_green  = ~sel_hact & sel_gact;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auto_h_green <= `RST_CFG_BIT;
    end else begin
      auto_h_green <= next_auto_green;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auto_v_sep <= `RST_CFG_BIT;
    end else begin
      auto_v_sep <= next_auto_green;
    end
  end

  // Hardware controls follow their register one cycle later
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_select_o <= `RST_CHAN;
    end else begin
      channel_select_o <= chan;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      differential_o <= `RST_CFG_BIT;
    end else begin
      differential_o <= input_configuration[`CFG_DIFF];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dc_coupled_o <= `RST_CFG_BIT;
    end else begin
      dc_coupled_o <= input_configuration[`CFG_DC];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      colour_format_select_o <= `RST_CFG_BIT;
    end else begin
      colour_format_select_o <= component_format;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      expanded_range_o <= `RST_CFG_BIT;
    end else begin
      expanded_range_o <= input_configuration[`CFG_RANGE];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clamp_source_select_o <= `RST_CFG_BIT;
    end else begin
      clamp_source_select_o <= input_configuration[`CFG_CLAMP_SRC];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clamp_polarity_select_o <= `RST_CFG_BIT;
    end else begin
      clamp_polarity_select_o <= input_configuration[`CFG_CLAMP_POL];
    end
  end

  // Level and target switch together with the format flag, never a cycle apart
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clamp_level_o <= `RST_CLAMP_LEVEL;
    end else begin
      clamp_level_o <= clamp_for(component_format);
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      black_target_o <= `RST_BLACK_TARGET;
    end else begin
      black_target_o <= target_for(component_format);
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hsync_from_green_o <= `RST_CFG_BIT;
    end else begin
      hsync_from_green_o <= pick_source(manual_sync,
                                        sync_source_selection[`SYNC_H_SRC],
                                        auto_h_green);
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vsync_from_separator_o <= `RST_CFG_BIT;
    end else begin
      vsync_from_separator_o <= pick_source(manual_sync,
                                            sync_source_selection[`SYNC_V_SRC],
                                            auto_v_sep);
    end
  end

  // The automatic pick stays readable even in manual mode, for diagnostics
  assign sync_chosen = {`CHOSEN_PAD, auto_v_sep, auto_h_green};

  always @* begin
    next_rdata = `NO_BITS;
    case (addr_i)
      `OFF_INT_STATUS:  next_rdata = interrupt_status;
      `OFF_INT_MASK:    next_rdata = interrupt_mask;
      `OFF_INPUT_CFG:   next_rdata = input_configuration;
      `OFF_SYNC_SEL:    next_rdata = sync_source_selection;
      `OFF_SYNC_CHOSEN: next_rdata = sync_chosen;
      default:          next_rdata = `NO_BITS;
    endcase
  end

  // Zero outside the answer cycle so a stray capture never sees stale data
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `RST_RDATA;
    end else if (read_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `RST_RDATA;
    end
  end

endmodule // afe_ctrl_regs

// [tb/afe_ctrl_regs_asserts.sv]
// Purpose: Port-level checks of the front-end control bank
// Assumes: Config outputs follow a register write by two edges
// Notes:   Watches design ports only
`timescale 1ns/10ps
module afe_ctrl_checker (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        write_i,
  input wire logic [3:0]  channel_sync_change_i,
  input wire logic        input_disrupted_i,
  input wire logic        input_settled_i,
  input wire logic        vsync_event_i,
  input wire logic        phase_adjust_done_i,
  input wire logic        irq_o,
  input wire logic [1:0]  channel_select_o,
  input wire logic        differential_o,
  input wire logic        dc_coupled_o,
  input wire logic        colour_format_select_o,
  input wire logic        expanded_range_o,
  input wire logic        clamp_source_select_o,
  input wire logic        clamp_polarity_select_o,
  input wire logic [2:0]  clamp_level_o,
  input wire logic [23:0] black_target_o,
  input wire logic        hsync_from_green_o,
  input wire logic        vsync_from_separator_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire any_ev = |{channel_sync_change_i, input_disrupted_i, input_settled_i, vsync_event_i,
                  phase_adjust_done_i};
  sequence s_cfg;
    write_i && addr_i == 8'h10;
  endsequence
  sequence s_manual;
    write_i && addr_i == 8'h11 && wdata_i[0] ##1 !write_i;
  endsequence
  AST_IRQ_CAUSE:
    assert property ($rose(irq_o) |-> $past(any_ev || (write_i && addr_i == 8'h05)))
    else $error("irq rose without event or mask write");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(write_i))
    else $error("irq fell without a host write");
  AST_CHAN: assert property (s_cfg |-> ##2 channel_select_o == $past(wdata_i[1:0], 2))
    else $error("channel select mismatch");
  AST_DIFF: assert property (s_cfg |-> ##2 differential_o == $past(wdata_i[2], 2))
    else $error("input mode mismatch");
  AST_DC: assert property (s_cfg |-> ##2 dc_coupled_o == $past(wdata_i[3], 2))
    else $error("coupling mismatch");
  AST_CLAMP:
    assert property (s_cfg |-> ##2 {clamp_polarity_select_o, clamp_source_select_o,
    expanded_range_o} == $past(wdata_i[7:5], 2))
    else $error("range or clamp select mismatch");
  AST_FORMAT:
    assert property ($stable(colour_format_select_o) |-> (colour_format_select_o ?
    clamp_level_o == 3'h5 && black_target_o == 24'h800080 :
    clamp_level_o == 3'h0 && black_target_o == 24'h000000))
    else $error("clamp level or black target wrong");
  AST_MANUAL:
    assert property (s_manual |-> ##1 {vsync_from_separator_o, hsync_from_green_o}
    == $past(wdata_i[2:1], 2))
    else $error("manual sync source mismatch");
endmodule // afe_ctrl_checker
bind afe_ctrl_regs afe_ctrl_checker afe_ctrl_checker_inst (.clock_i, .resetn_i, .addr_i,
  .wdata_i, .write_i, .channel_sync_change_i, .input_disrupted_i, .input_settled_i,
  .vsync_event_i, .phase_adjust_done_i, .irq_o, .channel_select_o, .differential_o,
  .dc_coupled_o, .colour_format_select_o, .expanded_range_o, .clamp_source_select_o,
  .clamp_polarity_select_o, .clamp_level_o, .black_target_o, .hsync_from_green_o,
  .vsync_from_separator_o);

// [tb/afe_host_model.sv]
// Purpose: Host controller driving the register strobe port
// Assumes: Read data stand only in the cycle after the strobe
// Notes:   One idle cycle between accesses keeps each strobe a single pulse
`timescale 1ns/10ps
module afe_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            write_o,
  output logic            read_o
);
  initial begin
    {addr_o, wdata_o, write_o, read_o} = 18'h0;
  end
  // Callers only pick channels 2 and 3 with single-ended mode set
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) {addr_o, wdata_o, write_o} <= {a, d, 1'b1};
    @(posedge clock_i) write_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i) {addr_o, read_o} <= {a, 1'b1};
    @(posedge clock_i) read_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule // afe_host_model

// [tb/test_video_afe_irq_and_input_config.sv]
// Purpose: Self-checking bench of the front-end control bank
// Assumes: Event inputs are single-cycle pulses
// Notes:   Each scenario checks its own results
`timescale 1ns/10ps
module test_video_afe_irq_and_input_config;
  logic clock_i = 0, resetn_i = 0;
  logic [7:0] addr, wdata, rdata, ev = 8'h00, v;
  logic write, read, irq_o, hs_from_g, vs_from_s;
  logic [3:0] hs_act = 4'h0, gs_act = 4'hF;
  logic [1:0] chan;
  logic [2:0] lvl;
  logic [23:0] tgt;
  logic [5:0] flags;
  int fail_count = 0, total_checks = 0;
  initial forever #2.5 clock_i = ~clock_i;
  afe_host_model afe_host_model_inst (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .write_o(write), .read_o(read));
  afe_ctrl_regs afe_ctrl_regs_inst (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr),
    .wdata_i(wdata), .write_i(write), .read_i(read), .rdata_o(rdata),
    .channel_sync_change_i(ev[3:0]), .input_disrupted_i(ev[4]), .input_settled_i(ev[5]),
    .vsync_event_i(ev[6]), .phase_adjust_done_i(ev[7]), .hsync_active_i(hs_act),
    .green_embedded_sync_active_i(gs_act), .irq_o(irq_o), .channel_select_o(chan),
    .differential_o(flags[0]), .dc_coupled_o(flags[1]), .colour_format_select_o(flags[2]),
    .expanded_range_o(flags[3]), .clamp_source_select_o(flags[4]),
    .clamp_polarity_select_o(flags[5]), .clamp_level_o(lvl), .black_target_o(tgt),
    .hsync_from_green_o(hs_from_g), .vsync_from_separator_o(vs_from_s));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    afe_host_model_inst.rd(a, v);
    chk(v, exp);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge clock_i) ev <= e;
    @(posedge clock_i) ev <= 8'h00;
  endtask
  task automatic t_reset;
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'hFF);
    rchk(8'h10, 8'h00);
    rchk(8'h11, 8'h00);
    rchk(8'h30, 8'h00);
  endtask
  task automatic t_events;
    afe_host_model_inst.wr(8'h05, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      rchk(8'h04, 8'h01 << i);
      chk(irq_o, 1'b1);
      afe_host_model_inst.wr(8'h04, 8'h01 << i);
      rchk(8'h04, 8'h00);
      chk(irq_o, 1'b0);
    end
  endtask
  task automatic t_masked;
    afe_host_model_inst.wr(8'h05, 8'hFF);
    pulse(8'hFF);
    #1 chk(irq_o, 1'b0);
    rchk(8'h04, 8'hFF);
    afe_host_model_inst.wr(8'h05, 8'h7F);
    #1 chk(irq_o, 1'b1);
    fork
      afe_host_model_inst.wr(8'h04, 8'hFF);
      pulse(8'h40);
    join
    rchk(8'h04, 8'h40);
  endtask
  task automatic t_config;
    logic [7:0] cfg [3] = '{8'h55, 8'hAA, 8'h13};
    foreach (cfg[i]) begin
      afe_host_model_inst.wr(8'h10, cfg[i]);
      @(posedge clock_i) #1;
      chk(chan, cfg[i][1:0]);
      chk(flags, cfg[i][7:2]);
      chk({lvl, tgt}, cfg[i][4] ? {3'h5, 24'h800080} : 27'h0);
    end
  endtask
  task automatic t_sync;
    for (int i = 1; i < 8; i += 2) begin
      afe_host_model_inst.wr(8'h11, i[7:0]);
      @(posedge clock_i) #1;
      chk({vs_from_s, hs_from_g}, i[2:1]);
    end
    afe_host_model_inst.wr(8'h11, 8'h00);
    repeat (8) @(posedge clock_i);
    rchk(8'h12, 8'h03);
    chk({vs_from_s, hs_from_g}, 2'b11);
    @(posedge clock_i) hs_act <= 4'hF;
    repeat (8) @(posedge clock_i);
    rchk(8'h12, 8'h00);
    chk({vs_from_s, hs_from_g}, 2'b00);
  endtask
  task automatic summarize;
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset;
    t_events;
    t_masked;
    t_config;
    t_sync;
    summarize;
  end
endmodule // test_video_afe_irq_and_input_config
